// File: logic/csc_clk_if.sv
// timing strobes shared from the common oscillator divider to the rate selectors
interface csc_clk_if;
    logic strobe_std;
    logic strobe_x2;
    logic half_rise;

    modport src  (output strobe_std, output strobe_x2, output half_rise);
    modport sink (input strobe_std, input strobe_x2, input half_rise);
endinterface : csc_clk_if

// File: logic/csc_osc_divider.sv
// common oscillator divider: one counter over twelve oscillator periods
module csc_osc_divider (
    input  wire logic i_clock,
    input  wire logic i_resetn,
    csc_clk_if.src    o_tim
);
    logic [csc_pkg::CSC_CNT_W-1:0] count;
    logic [csc_pkg::CSC_CNT_W-1:0] next_count;

    always_comb begin
        if (count == csc_pkg::CSC_CNT_LAST) begin
            next_count = csc_pkg::CSC_CNT_RESET;
        end else begin
            next_count = count + 4'h1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            count <= csc_pkg::CSC_CNT_RESET;
        end else begin
            count <= next_count;
        end
    end

    // every rate is cut from this one count so all blocks stay phase aligned
    assign o_tim.strobe_std = (count == csc_pkg::CSC_CNT_LAST);
    assign o_tim.strobe_x2  = (count == csc_pkg::CSC_CNT_LAST) || (count == csc_pkg::CSC_CNT_MID);
    // the halved oscillator is high on even counts; it rises after each odd count
    assign o_tim.half_rise  = count[0];
endmodule : csc_osc_divider

// File: logic/csc_pkg.sv
// constants for the cpu and peripheral speed select block
package csc_pkg;
    localparam logic [7:0] CSC_SPEED_CTRL_ADDR  = 8'h8f;
    localparam logic [7:0] CSC_SPEED_CTRL_RESET = 8'h00;
    localparam int         CSC_CPU_BIT          = 0;
    localparam int         CSC_TIMER0_BIT       = 1;
    localparam int         CSC_TIMER1_BIT       = 2;
    localparam int         CSC_TIMER2_BIT       = 3;
    localparam int         CSC_SERIAL_BIT       = 4;
    localparam int         CSC_COUNTER_BIT      = 5;
    localparam int         CSC_WATCHDOG_BIT     = 6;
    localparam int         CSC_CAN_BIT          = 7;
    localparam int         CSC_NUM_PERIPH       = 7;
    localparam int         CSC_STD_PERIODS      = 12;
    localparam int         CSC_X2_PERIODS       = 6;
    localparam int         CSC_CNT_W            = 4;
    localparam logic [3:0] CSC_CNT_RESET        = 4'h0;
    localparam logic [3:0] CSC_CNT_LAST         = 4'(CSC_STD_PERIODS - 1);
    localparam logic [3:0] CSC_CNT_MID          = 4'(CSC_X2_PERIODS - 1);
endpackage : csc_pkg

// File: logic/csc_rate_sel.sv
// picks standard or double rate enables for one clock consumer
module csc_rate_sel (
    input  wire logic i_fast,
    csc_clk_if.sink   i_tim,
    output logic      o_cycle_en,
    output logic      o_phase_en
);
    // fast: 6 oscillator periods per cycle, divider bypassed; else 12 via the halved clock
    assign o_cycle_en = i_fast ? i_tim.strobe_x2 : i_tim.strobe_std;
    assign o_phase_en = i_fast ? 1'b1 : i_tim.half_rise;
endmodule : csc_rate_sel

// File: logic/csc_speed_select.sv
// cpu and peripheral clock speed select with its control register

module csc_speed_select (
    input  wire logic                               i_clock,
    input  wire logic                               i_resetn,
    input  wire logic                               i_boot_fast_clock_option,
    input  wire logic [7:0]                         i_sfr_addr,
    input  wire logic                               i_sfr_wr,
    input  wire logic [7:0]                         i_sfr_wdata,
    output logic      [7:0]                         o_sfr_rdata,
    output logic                                    o_cpu_phase_en,
    output logic                                    o_cpu_cycle_en,
    output logic                                    o_cpu_double_speed,
    output logic      [csc_pkg::CSC_NUM_PERIPH-1:0] o_periph_cycle_en,
    output logic      [csc_pkg::CSC_NUM_PERIPH-1:0] o_periph_double_speed
);
    logic [7:0]                         clock_speed_control;
    logic [7:0]                         next_clock_speed_control;
    logic                               boot_done;
    logic                               next_boot_done;
    logic [7:0]                         applied;
    logic [7:0]                         next_applied;
    logic [7:0]                         rdata;
    logic [7:0]                         next_rdata;
    logic [csc_pkg::CSC_NUM_PERIPH-1:0] periph_fast;
    logic                               sfr_hit;

    csc_clk_if tim ();

    csc_osc_divider u_divider (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .o_tim    (tim.src)
    );

    assign sfr_hit = (i_sfr_addr == csc_pkg::CSC_SPEED_CTRL_ADDR);

    // control register: reset clears it, the boot option is caught on the first edge
    // after release so the asynchronous-free reset still loads only a constant
    always_comb begin
        next_clock_speed_control = clock_speed_control;
        next_boot_done           = 1'b1;
        if (!boot_done) begin
            next_clock_speed_control[csc_pkg::CSC_CPU_BIT] = i_boot_fast_clock_option;
        end
        if (i_sfr_wr && sfr_hit) begin
            next_clock_speed_control = i_sfr_wdata;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            clock_speed_control <= csc_pkg::CSC_SPEED_CTRL_RESET;
            boot_done           <= 1'b0;
        end else begin
            clock_speed_control <= next_clock_speed_control;
            boot_done           <= next_boot_done;
        end
    end

    // the applied copy follows software only at a halved-clock rising edge,
    // so a switch never cuts a phase short
    always_comb begin
        next_applied = applied;
        if (tim.half_rise) begin
            next_applied = clock_speed_control;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            applied <= csc_pkg::CSC_SPEED_CTRL_RESET;
        end else begin
            applied <= next_applied;
        end
    end

    // read data is registered: it answers one clock after the address
    always_comb begin
        next_rdata = 8'h00;
        if (sfr_hit) begin
            next_rdata = clock_speed_control;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign o_sfr_rdata = rdata;

    // cpu bit sets the cpu rate and also each peripheral rate whose own select is clear
    csc_rate_sel u_cpu_rate (
        .i_fast     (applied[csc_pkg::CSC_CPU_BIT]),
        .i_tim      (tim.sink),
        .o_cycle_en (o_cpu_cycle_en),
        .o_phase_en (o_cpu_phase_en)
    );

    assign o_cpu_double_speed = applied[csc_pkg::CSC_CPU_BIT];

    // peripheral order: timer0, timer1, timer2, serial, counter array, watchdog, can
    for (genvar g = 0; g < csc_pkg::CSC_NUM_PERIPH; g++) begin : g_periph
        // fast only with the cpu bit set and the own select clear
        assign periph_fast[g] = applied[csc_pkg::CSC_CPU_BIT] && !applied[g + 1];

        // a fast peripheral gets twice as many cycle enables, halving its time base
        csc_rate_sel u_periph_rate (
            .i_fast     (periph_fast[g]),
            .i_tim      (tim.sink),
            .o_cycle_en (o_periph_cycle_en[g]),
            // peripherals count machine cycles only, they have no phase clock
            .o_phase_en ()
        );
    end

    assign o_periph_double_speed = periph_fast;
endmodule : csc_speed_select

// File: verif/csc_osc_model.sv
// oscillator source that feeds the speed select block
module csc_osc_model (
    output logic o_clock
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_clock = 1'b0;
        forever #5 o_clock = ~o_clock;
    end
endmodule : csc_osc_model

// File: verif/csc_speed_select_assertions.sv
// concurrent checks on the speed select ports
module csc_speed_checker (
    input wire logic                               i_clock,
    input wire logic                               i_resetn,
    input wire logic [7:0]                         i_sfr_addr,
    input wire logic [7:0]                         o_sfr_rdata,
    input wire logic                               o_cpu_phase_en,
    input wire logic                               o_cpu_cycle_en,
    input wire logic                               o_cpu_double_speed,
    input wire logic [csc_pkg::CSC_NUM_PERIPH-1:0] o_periph_cycle_en,
    input wire logic [csc_pkg::CSC_NUM_PERIPH-1:0] o_periph_double_speed
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    sequence std_pulse;
        o_cpu_cycle_en && !o_cpu_double_speed;
    endsequence
    sequence fast_run;
        o_cpu_cycle_en ##1 o_cpu_double_speed [*6];
    endsequence
    std_gap_a: assert property (std_pulse |=> !o_cpu_cycle_en [*5])
        else $error("standard machine cycle too short");
    fast_cadence_a: assert property (fast_run |-> o_cpu_cycle_en)
        else $error("double speed machine cycle not six periods");
    half_phase_a: assert property (o_cpu_phase_en && !o_cpu_double_speed ##1
        !o_cpu_double_speed |-> !o_cpu_phase_en)
        else $error("standard phase clock not halved");
    bypass_phase_a: assert property (o_cpu_double_speed |-> o_cpu_phase_en)
        else $error("phase enable missing in double speed");
    periph_std_a: assert property (!o_cpu_double_speed |-> o_periph_double_speed == '0)
        else $error("peripheral fast while cpu standard");
    common_div_a: assert property (o_periph_cycle_en != '0 |-> o_cpu_cycle_en)
        else $error("peripheral pulse off the common divider");
    periph_fast_a: assert property (o_cpu_cycle_en |->
        (o_periph_cycle_en & o_periph_double_speed) == o_periph_double_speed)
        else $error("fast peripheral missed a pulse");
    half_edge_a: assert property ($rose(o_cpu_double_speed) |-> $past(o_cpu_phase_en))
        else $error("speed change off the halved clock edge");
    reset_std_a: assert property ($rose(i_resetn) |-> !o_cpu_double_speed
        && o_sfr_rdata == 8'h00)
        else $error("not standard speed after reset");
    read_other_a: assert property (i_sfr_addr != csc_pkg::CSC_SPEED_CTRL_ADDR |=>
        o_sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule : csc_speed_checker
bind csc_speed_select csc_speed_checker chk (.i_clock, .i_resetn, .i_sfr_addr, .o_sfr_rdata,
    .o_cpu_phase_en, .o_cpu_cycle_en, .o_cpu_double_speed, .o_periph_cycle_en,
    .o_periph_double_speed);

// File: verif/csc_speed_select_test.sv
// register driven bench for the cpu and peripheral speed select block
module csc_speed_select_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk;
    logic       i_resetn;
    logic       boot;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] d;
    logic [6:0] pcyc;
    logic [6:0] pds;
    logic       phase;
    logic       cyc_en;
    logic       ds;
    int         err_count;
    int         total_checks;
    int         cyc;
    int         n;
    wire  [7:0] en = {cyc_en, pcyc};
    csc_osc_model osc (.o_clock(clk));
    csc_speed_select uut (.i_clock(clk), .i_resetn(i_resetn), .i_boot_fast_clock_option(boot),
        .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata),
        .o_cpu_phase_en(phase), .o_cpu_cycle_en(cyc_en), .o_cpu_double_speed(ds),
        .o_periph_cycle_en(pcyc), .o_periph_double_speed(pds));
    task conclude;
        if (err_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // mode changes land within two edges, the third negedge sees them settled
    task wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        repeat (3) @(negedge clk);
    endtask : wr_reg
    task rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        @(negedge clk);
        d = rdata;
    endtask : rd_reg
    task period(input int k);
        n = 0;
        do @(negedge clk); while (en[k] !== 1'b1);
        do begin
            @(negedge clk);
            n++;
        end while (en[k] !== 1'b1);
    endtask : period
    task phases;
        n = 0;
        repeat (12) begin
            @(negedge clk);
            if (phase === 1'b1) n++;
        end
    endtask : phases
    task do_reset(input logic b);
        @(posedge clk);
        boot <= b;
        i_resetn <= 1'b0;
        repeat (2) @(posedge clk);
        i_resetn <= 1'b1;
    endtask : do_reset
    always @(posedge clk) begin
        cyc++;
        if (cyc > 2000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        {i_resetn, boot, wr, addr, wdata} = '0;
        do_reset(1'b0);
        rd_reg(8'h8f);
        check("reset value", d, csc_pkg::CSC_SPEED_CTRL_RESET);
        check("reset speed flag", {7'h00, ds}, 8'h00);
        period(7);
        check("std cpu cycle", 8'(n), 8'h0c);
        phases;
        check("std phase count", 8'(n), 8'h06);
        wr_reg(8'h8f, 8'hff);
        period(7);
        check("fast cpu cycle", 8'(n), 8'h06);
        check("cpu fast flag", {7'h00, ds}, 8'h01);
        check("periph held", {1'b0, pds}, 8'h00);
        period(0);
        check("held timer0 cycle", 8'(n), 8'h0c);
        phases;
        check("bypass phase count", 8'(n), 8'h0c);
        wr_reg(8'h8f, 8'h55);
        check("periph mix", {1'b0, pds}, 8'h55);
        period(0);
        check("fast timer0 cycle", 8'(n), 8'h06);
        period(6);
        check("fast can cycle", 8'(n), 8'h06);
        period(1);
        check("held timer1 cycle", 8'(n), 8'h0c);
        wr_reg(8'h8e, 8'h00);
        rd_reg(8'h8e);
        check("unmapped read", d, 8'h00);
        rd_reg(8'h8f);
        check("readback", d, 8'h55);
        wr_reg(8'h8f, 8'haa);
        check("periph ignored", {1'b0, pds}, 8'h00);
        check("cpu std flag", {7'h00, ds}, 8'h00);
        period(7);
        check("back to std", 8'(n), 8'h0c);
        do_reset(1'b1);
        rd_reg(8'h8f);
        check("boot option", d, 8'h01);
        period(7);
        check("boot fast cycle", 8'(n), 8'h06);
        check("boot fast flag", {7'h00, ds}, 8'h01);
        conclude();
    end
endmodule : csc_speed_select_test
